// *** rtl/rtcaw_top.sv ***
`timescale 1ns/1ps

module rtcaw_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire rtcaw_pkg::rtcaw_osc_t osc_sel,
  input wire logic internal_rc_oscillator,
  input wire logic xtal_oscillator,
  input wire rtcaw_pkg::rtcaw_cmd_t cmd,
  output rtcaw_pkg::rtcaw_stat_t stat
);

  // ****************************************************************
  // Tick generation
  // ****************************************************************
  logic osc_lvl_reg;
  logic osc_lvl_next;
  logic osc_tick_reg;
  logic osc_tick_next;
  logic [rtcaw_pkg::KHZ_DIV_W-1:0] khz_div_reg;
  logic [rtcaw_pkg::KHZ_DIV_W-1:0] khz_div_next;
  logic [rtcaw_pkg::HZ_DIV_W-1:0] hz_div_reg;
  logic [rtcaw_pkg::HZ_DIV_W-1:0] hz_div_next;
  logic khz_tick;
  logic hz_tick;
  logic osc_src;

  function automatic logic div_wrap(input logic [15:0] cnt, input logic [15:0] last);
    div_wrap = (cnt == last);
  endfunction

  always_comb begin
    osc_src = (osc_sel == rtcaw_pkg::OSC_XTAL) ? xtal_oscillator : internal_rc_oscillator;
    osc_lvl_next = osc_src;
    osc_tick_next = osc_src && !osc_lvl_reg;
    khz_tick = osc_tick_reg && div_wrap(16'(khz_div_reg), 16'(rtcaw_pkg::KHZ_DIV_LAST));
    hz_tick = khz_tick && div_wrap(16'(hz_div_reg), 16'(rtcaw_pkg::HZ_DIV_LAST));
    khz_div_next = khz_div_reg;
    hz_div_next = hz_div_reg;
    if (osc_tick_reg) begin
      khz_div_next = khz_tick ? rtcaw_pkg::KHZ_DIV_RST
                              : khz_div_reg + rtcaw_pkg::KHZ_DIV_W'(1);
    end
    if (khz_tick) begin
      hz_div_next = hz_tick ? rtcaw_pkg::HZ_DIV_RST
                            : hz_div_reg + rtcaw_pkg::HZ_DIV_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_lvl_reg <= 1'b0;
      osc_tick_reg <= 1'b0;
      khz_div_reg <= rtcaw_pkg::KHZ_DIV_RST;
      hz_div_reg <= rtcaw_pkg::HZ_DIV_RST;
    end else begin
      osc_lvl_reg <= osc_lvl_next;
      osc_tick_reg <= osc_tick_next;
      khz_div_reg <= khz_div_next;
      hz_div_reg <= hz_div_next;
    end
  end

  // ****************************************************************
  // Seconds counter and alarm
  // ****************************************************************
  logic [rtcaw_pkg::SEC_W-1:0] sec_reg;
  logic [rtcaw_pkg::SEC_W-1:0] sec_next;
  logic [rtcaw_pkg::SEC_W-1:0] alarm_reg;
  logic [rtcaw_pkg::SEC_W-1:0] alarm_next;
  logic sec_moved;
  logic alarm_irq_reg;
  logic alarm_irq_next;

  always_comb begin
    sec_next = sec_reg;
    sec_moved = 1'b0;
    if (cmd.sec_clr) begin
      sec_next = rtcaw_pkg::SEC_RST;
      sec_moved = 1'b1;
    end else if (cmd.sec_load) begin
      sec_next = cmd.sec_load_val;
      sec_moved = 1'b1;
    end else if (cmd.sec_en && hz_tick) begin
      sec_next = sec_reg + rtcaw_pkg::SEC_ONE;
      sec_moved = 1'b1;
    end
    alarm_next = cmd.alarm_wr ? cmd.alarm_val : alarm_reg;
    // Fires once on arriving at the match value
    alarm_irq_next = sec_moved && (sec_next == alarm_next);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sec_reg <= rtcaw_pkg::SEC_RST;
      alarm_reg <= rtcaw_pkg::ALARM_RST;
      alarm_irq_reg <= 1'b0;
    end else begin
      sec_reg <= sec_next;
      alarm_reg <= alarm_next;
      alarm_irq_reg <= alarm_irq_next;
    end
  end

  // ****************************************************************
  // Millisecond wake-up timer
  // ****************************************************************
  typedef enum logic {
    MS_IDLE,
    MS_RUN
  } rtcaw_ms_state_t;

  rtcaw_ms_state_t ms_state_reg;
  rtcaw_ms_state_t ms_state_next;
  logic [rtcaw_pkg::MS_W-1:0] ms_reg;
  logic [rtcaw_pkg::MS_W-1:0] ms_next;
  logic ms_irq_reg;
  logic ms_irq_next;
  logic ms_start;

  always_comb begin
    ms_state_next = ms_state_reg;
    ms_next = ms_reg;
    ms_irq_next = 1'b0;
    // Zero writes are dropped entirely
    ms_start = cmd.ms_wr && (cmd.ms_val != rtcaw_pkg::MS_RST);
    if (ms_start) begin
      // Full 16-bit load gives up to 65535 ms
      ms_next = cmd.ms_val;
      ms_state_next = MS_RUN;
    end else begin
      case (ms_state_reg)
        MS_IDLE: begin
          ms_state_next = MS_IDLE;
        end
        MS_RUN: begin
          if (khz_tick) begin
            ms_next = ms_reg - rtcaw_pkg::MS_ONE;
            if (ms_reg == rtcaw_pkg::MS_ONE) begin
              ms_irq_next = 1'b1;
              ms_state_next = MS_IDLE;
            end
          end
        end
        default: begin
          ms_state_next = MS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ms_state_reg <= MS_IDLE;
      ms_reg <= rtcaw_pkg::MS_RST;
      ms_irq_reg <= 1'b0;
    end else begin
      ms_state_reg <= ms_state_next;
      ms_reg <= ms_next;
      ms_irq_reg <= ms_irq_next;
    end
  end

  // ****************************************************************
  // Wake-up request and outputs
  // ****************************************************************
  logic wake_reg;
  logic wake_next;

  always_comb begin
    wake_next = cmd.low_power && (alarm_irq_next || ms_irq_next);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= wake_next;
    end
  end

  always_comb begin
    stat.sec_count = sec_reg;
    stat.ms_count = ms_reg;
    stat.ms_running = (ms_state_reg == MS_RUN);
    stat.alarm_irq = alarm_irq_reg;
    stat.ms_irq = ms_irq_reg;
    stat.wakeup_req = wake_reg;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_khz_rate;
    @(posedge clk) disable iff (sys_rst)
      khz_tick |-> osc_tick_reg && khz_div_reg == rtcaw_pkg::KHZ_DIV_LAST
        ##1 khz_div_reg == rtcaw_pkg::KHZ_DIV_RST;
  endproperty
  a_khz_rate: assert property (p_khz_rate) else $error("kHz tick off rate");

  property p_hz_rate;
    @(posedge clk) disable iff (sys_rst)
      hz_tick |-> khz_tick && hz_div_reg == rtcaw_pkg::HZ_DIV_LAST;
  endproperty
  a_hz_rate: assert property (p_hz_rate) else $error("Hz tick off rate");

  property p_sec_clr;
    @(posedge clk) disable iff (sys_rst)
      cmd.sec_clr |=> stat.sec_count == rtcaw_pkg::SEC_RST;
  endproperty
  a_sec_clr: assert property (p_sec_clr) else $error("Seconds not cleared");

  property p_sec_inc;
    @(posedge clk) disable iff (sys_rst)
      cmd.sec_en && hz_tick && !cmd.sec_clr && !cmd.sec_load
        |=> stat.sec_count == $past(stat.sec_count) + rtcaw_pkg::SEC_ONE;
  endproperty
  a_sec_inc: assert property (p_sec_inc) else $error("Seconds missed tick");

  property p_alarm;
    @(posedge clk) disable iff (sys_rst)
      stat.alarm_irq |-> stat.sec_count == alarm_reg && $past(sec_moved);
  endproperty
  a_alarm: assert property (p_alarm) else $error("Alarm without match");

  property p_ms_dec;
    @(posedge clk) disable iff (sys_rst)
      stat.ms_running && khz_tick && !cmd.ms_wr
        |=> stat.ms_count == $past(stat.ms_count) - rtcaw_pkg::MS_ONE;
  endproperty
  a_ms_dec: assert property (p_ms_dec) else $error("Timer missed decrement");

  property p_ms_start;
    @(posedge clk) disable iff (sys_rst)
      cmd.ms_wr && cmd.ms_val != rtcaw_pkg::MS_RST
        |=> stat.ms_running && stat.ms_count == $past(cmd.ms_val);
  endproperty
  a_ms_start: assert property (p_ms_start) else $error("Timer did not start");

  property p_ms_end;
    @(posedge clk) disable iff (sys_rst)
      $fell(stat.ms_running) |-> stat.ms_irq && stat.ms_count == rtcaw_pkg::MS_RST;
  endproperty
  a_ms_end: assert property (p_ms_end) else $error("Timer stopped without timeout");

  property p_wake;
    @(posedge clk) disable iff (sys_rst)
      (stat.alarm_irq || stat.ms_irq) && $past(cmd.low_power) |-> stat.wakeup_req;
  endproperty
  a_wake: assert property (p_wake) else $error("Missing wake-up request");

  property p_zero_wr;
    @(posedge clk) disable iff (sys_rst)
      cmd.ms_wr && cmd.ms_val == rtcaw_pkg::MS_RST && !stat.ms_running
        |=> !stat.ms_running && !stat.ms_irq;
  endproperty
  a_zero_wr: assert property (p_zero_wr) else $error("Zero write started timer");

  property p_khz_step;
    @(posedge clk) disable iff (sys_rst)
      osc_tick_reg && !khz_tick
        |=> khz_div_reg == $past(khz_div_reg) + rtcaw_pkg::KHZ_DIV_W'(1);
  endproperty
  a_khz_step: assert property (p_khz_step) else $error("kHz divider skipped");

  property p_hz_step;
    @(posedge clk) disable iff (sys_rst)
      khz_tick && !hz_tick
        |=> hz_div_reg == $past(hz_div_reg) + rtcaw_pkg::HZ_DIV_W'(1);
  endproperty
  a_hz_step: assert property (p_hz_step) else $error("Hz divider skipped");

  property p_sec_load;
    @(posedge clk) disable iff (sys_rst)
      cmd.sec_load && !cmd.sec_clr
        |=> stat.sec_count == $past(cmd.sec_load_val);
  endproperty
  a_sec_load: assert property (p_sec_load) else $error("Seconds not loaded");

  property p_sec_hold;
    @(posedge clk) disable iff (sys_rst)
      !cmd.sec_clr && !cmd.sec_load && !(cmd.sec_en && hz_tick)
        |=> $stable(stat.sec_count);
  endproperty
  a_sec_hold: assert property (p_sec_hold) else $error("Seconds moved without cause");

  property p_ms_idle;
    @(posedge clk) disable iff (sys_rst)
      !stat.ms_running && !(cmd.ms_wr && cmd.ms_val != rtcaw_pkg::MS_RST)
        |=> !stat.ms_running && $stable(stat.ms_count);
  endproperty
  a_ms_idle: assert property (p_ms_idle) else $error("Idle timer moved");

  property p_wake_only;
    @(posedge clk) disable iff (sys_rst)
      stat.wakeup_req
        |-> (stat.alarm_irq || stat.ms_irq) && $past(cmd.low_power);
  endproperty
  a_wake_only: assert property (p_wake_only) else $error("Wake-up without request");

endmodule

// *** include/rtcaw_pkg.sv ***
package rtcaw_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int SEC_W = 32;
  localparam int MS_W = 16;
  localparam int KHZ_DIV_W = 5;
  localparam int HZ_DIV_W = 10;

  // ****************************************************************
  // Tick rates
  // ****************************************************************
  localparam int OSC_HZ = 32000;
  localparam int KHZ_HZ = 1000;
  localparam int HZ_HZ = 1;
  localparam logic [KHZ_DIV_W-1:0] KHZ_DIV_LAST = KHZ_DIV_W'(OSC_HZ / KHZ_HZ - 1);
  localparam logic [HZ_DIV_W-1:0] HZ_DIV_LAST = HZ_DIV_W'(KHZ_HZ / HZ_HZ - 1);
  localparam logic [KHZ_DIV_W-1:0] KHZ_DIV_RST = 5'h00;
  localparam logic [HZ_DIV_W-1:0] HZ_DIV_RST = 10'h000;

  // ****************************************************************
  // Reset values and unit steps
  // ****************************************************************
  localparam logic [SEC_W-1:0] SEC_RST = 32'h0000_0000;
  localparam logic [SEC_W-1:0] ALARM_RST = 32'hFFFF_FFFF;
  localparam logic [MS_W-1:0] MS_RST = 16'h0000;
  localparam logic [MS_W-1:0] MS_ONE = 16'h0001;
  localparam logic [SEC_W-1:0] SEC_ONE = 32'h0000_0001;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic {
    OSC_RC,
    OSC_XTAL
  } rtcaw_osc_t;

  typedef struct packed {
    logic sec_en;
    logic sec_clr;
    logic sec_load;
    logic [SEC_W-1:0] sec_load_val;
    logic alarm_wr;
    logic [SEC_W-1:0] alarm_val;
    logic ms_wr;
    logic [MS_W-1:0] ms_val;
    logic low_power;
  } rtcaw_cmd_t;

  typedef struct packed {
    logic [SEC_W-1:0] sec_count;
    logic [MS_W-1:0] ms_count;
    logic ms_running;
    logic alarm_irq;
    logic ms_irq;
    logic wakeup_req;
  } rtcaw_stat_t;

endpackage

// *** tb/rtcaw_top_tb.sv ***
`timescale 1ns/1ps
module rtcaw_top_tb;
  // ****************************************************************
  // Stimulus and observation
  // ****************************************************************
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  rtcaw_pkg::rtcaw_osc_t osc_sel = rtcaw_pkg::OSC_RC;
  logic osc_ph = 1'b0;
  logic rc_run = 1'b0;
  logic xt_run = 1'b0;
  rtcaw_pkg::rtcaw_cmd_t cmd = '0;
  rtcaw_pkg::rtcaw_stat_t stat;
  logic [31:0] seed = 32'h0000_E1AD;
  logic [31:0] v;
  int failures = 0;
  int total_checks = 0;

  always #50 clk = ~clk;
  always @(negedge clk) osc_ph <= ~osc_ph;

  rtcaw_top dut_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .osc_sel(osc_sel),
    .internal_rc_oscillator(rc_run & osc_ph),
    .xtal_oscillator(xt_run & osc_ph),
    .cmd(cmd),
    .stat(stat)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // Osc edge every 2 cycles, 32 osc ticks per ms tick
  function automatic int kilo_gap();
    return 2 * (rtcaw_pkg::OSC_HZ / rtcaw_pkg::KHZ_HZ);
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One-cycle command, called on a falling edge
  task automatic send(input logic clr, input logic ld, input logic [31:0] sv,
                      input logic aw, input logic [31:0] av, input logic mw,
                      input logic [15:0] mv);
    rtcaw_pkg::rtcaw_cmd_t c;
    c = cmd;
    c.sec_clr = clr;
    c.sec_load = ld;
    c.sec_load_val = sv;
    c.alarm_wr = aw;
    c.alarm_val = av;
    c.ms_wr = mw;
    c.ms_val = mv;
    cmd <= c;
    @(negedge clk);
    c.sec_clr = 1'b0;
    c.sec_load = 1'b0;
    c.alarm_wr = 1'b0;
    c.ms_wr = 1'b0;
    cmd <= c;
  endtask

  task automatic ms_watch(input logic [15:0] n, input logic lp);
    int last;
    logic [15:0] prev;
    prev = stat.ms_count;
    last = -1;
    for (int i = 0; i < 70 * n + 200; i++) begin
      @(negedge clk);
      if (stat.ms_count !== prev) begin
        if (last >= 0) check("ms_gap", 32'(i - last), 32'(kilo_gap()));
        check("ms_step", 32'(stat.ms_count), 32'(prev - 16'h0001));
        last = i;
        prev = stat.ms_count;
      end
      if (stat.ms_irq === 1'b1) begin
        check("ms_end", 32'({stat.ms_running, stat.ms_count}), 32'h0000_0000);
        check("ms_wake", 32'(stat.wakeup_req), 32'(lp));
        repeat (130) @(negedge clk);
        check("ms_idle", 32'({stat.ms_irq, stat.ms_running, stat.ms_count}), 32'h0);
        return;
      end
    end
    failures++;
    print_verdict();
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (6) @(negedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check("sec_rst", stat.sec_count, rtcaw_pkg::SEC_RST);
    check("ms_rst", 32'({stat.ms_running, stat.ms_count}), 32'h0);
    $display("test reset done");
    rc_run <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      seed = xs(seed);
      @(negedge clk);
      send(1'b0, 1'b0, 32'h0, 1'b0, 32'h0, 1'b1, 16'(3 + seed[1:0]));
      check("ms_load", 32'({stat.ms_running, stat.ms_count}), 32'(17'h10003 + seed[1:0]));
      @(negedge clk);
      // Sleep entered right after the write on the first pass only, awake again at the end
      cmd.low_power <= ~k[0];
      ms_watch(16'(3 + seed[1:0]), ~k[0]);
    end
    $display("test ms_countdown done");
    send(1'b0, 1'b0, 32'h0, 1'b0, 32'h0, 1'b1, 16'h0000);
    for (int i = 0; i < 130; i++) begin
      check("zero_idle", 32'({stat.ms_irq, stat.ms_running}), 32'h0);
      @(negedge clk);
    end
    send(1'b0, 1'b0, 32'h0, 1'b0, 32'h0, 1'b1, 16'hFFFF);
    check("ms_full", 32'({stat.ms_running, stat.ms_count}), 32'h0001_FFFF);
    @(negedge clk);
    send(1'b0, 1'b0, 32'h0, 1'b0, 32'h0, 1'b1, 16'h0000);
    check("zero_run", 32'(stat.ms_running), 32'h1);
    @(negedge clk);
    send(1'b0, 1'b0, 32'h0, 1'b0, 32'h0, 1'b1, 16'h0002);
    check("ms_reload", 32'(stat.ms_count), 32'h2);
    ms_watch(16'h0002, 1'b0);
    $display("test ms_zero_reload done");
    rc_run <= 1'b0;
    xt_run <= 1'b1;
    osc_sel <= rtcaw_pkg::OSC_XTAL;
    @(negedge clk);
    send(1'b0, 1'b0, 32'h0, 1'b0, 32'h0, 1'b1, 16'h0003);
    ms_watch(16'h0003, 1'b0);
    osc_sel <= rtcaw_pkg::OSC_RC;
    @(negedge clk);
    send(1'b0, 1'b0, 32'h0, 1'b0, 32'h0, 1'b1, 16'h0002);
    repeat (200) @(negedge clk);
    check("osc_unsel", 32'(stat.ms_count), 32'h2);
    $display("test osc_select done");
    cmd.low_power <= 1'b1;
    seed = xs(seed);
    v = seed;
    @(negedge clk);
    send(1'b0, 1'b1, v, 1'b1, v, 1'b0, 16'h0);
    check("sec_load", stat.sec_count, v);
    check("alarm_load", 32'({stat.alarm_irq, stat.wakeup_req}), 32'h3);
    @(negedge clk);
    send(1'b0, 1'b0, 32'h0, 1'b1, v, 1'b0, 16'h0);
    check("alarm_wr_only", 32'(stat.alarm_irq), 32'h0);
    seed = xs(seed);
    @(negedge clk);
    send(1'b1, 1'b1, seed, 1'b0, 32'h0, 1'b0, 16'h0);
    check("sec_clr", stat.sec_count, 32'h0);
    @(negedge clk);
    $display("test alarm_load done");
    cmd.low_power <= 1'b0;
    xt_run <= 1'b0;
    rc_run <= 1'b1;
    cmd.sec_en <= 1'b1;
    @(negedge clk);
    send(1'b1, 1'b0, 32'h0, 1'b1, rtcaw_pkg::SEC_ONE, 1'b0, 16'h0);
    for (int i = 0; i <= 66000; i++) begin
      @(negedge clk);
      if (stat.sec_count !== 32'h0) begin
        check("sec_tick", stat.sec_count, 32'h1);
        check("alarm_tick", 32'({stat.alarm_irq, stat.wakeup_req}), 32'h2);
        break;
      end
      if (i == 66000) begin
        failures++;
        print_verdict();
      end
    end
    $display("test second_tick done");
    print_verdict();
  end
endmodule
